// ### core/memory_size_and_program_mode.sv
// Purpose: Capacity select register on APB plus flash programming mode entry
// Assumes: ref_clk is the main system clock, pins asynchronous to it
// Notes:   One wait state on every APB access; prohibited codes stored but flagged
`include "msps_consts.svh"
`default_nettype none
module memory_size_and_program_mode (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        flash_mode_pin,
  input  wire logic        programming_receive_line,
  input  wire logic        alternate_receive_line,
  output logic             programming_transmit_line,
  output logic             prog_mode,
  output logic             hold_pins_reset_state,
  output logic             alt_pair_disabled,
  output logic             sel_crystal_clock,
  output logic             sel_external_clock,
  output logic             internal_osc_enable,
  output logic             baud_locked,
  output logic      [11:0] rx_bit_period,
  output logic      [10:0] hs_ram_bytes,
  output logic       [5:0] rom_kbytes
);
  msps_pkg::mode_state_type state_ff;
  msps_pkg::mode_state_type nxt_state;
  msps_pkg::clk_src_type    clk_src_ff;
  msps_pkg::clk_src_type    nxt_clk_src;

  logic  [7:0] mcr_ff;
  logic  [2:0] settle_ff;
  logic  [2:0] pulse_cnt_ff;
  logic [11:0] period_cnt_ff;
  logic [11:0] bit_period_ff;
  logic        locked_ff;
  logic        pready_ff;
  logic        pslverr_ff;
  logic [31:0] prdata_ff;
  logic [10:0] ram_bytes_ff;
  logic  [5:0] rom_kb_ff;
  logic [10:0] nxt_ram_bytes;
  logic  [5:0] nxt_rom_kb;

  pin_sync_if mode_sync ();
  pin_sync_if rx_sync ();

  // Mode pin idles low, serial line idles high
  pin_filter #(.IDLE(1'b0)) u_mode_filter (
    .ref_clk (ref_clk),
    .rst     (rst),
    .raw     (flash_mode_pin),
    .sync    (mode_sync)
  );

  // primary pair only
  // Alternate receive pin is never sampled, so it cannot start a write
  pin_filter #(.IDLE(1'b1)) u_rx_filter (
    .ref_clk (ref_clk),
    .rst     (rst),
    .raw     (programming_receive_line),
    .sync    (rx_sync)
  );

  // APB decode
  wire acc       = psel & penable;
  wire hit_mcr   = (paddr == `MCR_ADDR);
  wire hit_stat  = (paddr == `STATUS_ADDR);
  wire mapped    = hit_mcr | hit_stat;
  wire take      = acc & pready_ff;
  wire answer    = acc & ~pready_ff;
  // byte write
  // Only the low byte lane carries the capacity register
  wire mcr_write = take & pwrite & hit_mcr;

  wire [2:0] ram_code = mcr_ff[7:`RAM_FIELD_LSB];
  wire       ram_ok   = (ram_code == `RAM_SEL_768) | (ram_code == `RAM_SEL_512) |
                        (ram_code == `RAM_SEL_1024);
  wire [3:0] rom_code = mcr_ff[`ROM_FIELD_MSB:0];
  wire       rom_ok   = (rom_code == `ROM_SEL_8K) | (rom_code == `ROM_SEL_16K) |
                        (rom_code == `ROM_SEL_24K) | (rom_code == `ROM_SEL_32K);

  // Status word built from live state
  wire [31:0] status_word = {11'h000,
                             bit_period_ff,
                             locked_ff,
                             rom_ok,
                             ram_ok,
                             pulse_cnt_ff,
                             clk_src_ff,
                             (state_ff != msps_pkg::st_normal) &&
                             (state_ff != msps_pkg::st_strap)};
  wire [31:0] read_word   = hit_mcr ? {24'h000000, mcr_ff} :
                            hit_stat ? status_word : 32'h00000000;

  always_comb begin
    case (ram_code)
      `RAM_SEL_768:  nxt_ram_bytes = 11'h300;
      `RAM_SEL_512:  nxt_ram_bytes = 11'h200;
      `RAM_SEL_1024: nxt_ram_bytes = 11'h400;
      default:       nxt_ram_bytes = 11'h000;
    endcase
  end

  always_comb begin
    case (rom_code)
      `ROM_SEL_8K:  nxt_rom_kb = 6'h08;
      `ROM_SEL_16K: nxt_rom_kb = 6'h10;
      `ROM_SEL_24K: nxt_rom_kb = 6'h18;
      `ROM_SEL_32K: nxt_rom_kb = 6'h20;
      default:      nxt_rom_kb = 6'h00;
    endcase
  end

  // pulse count to clock
  // Counts other than zero and three leave no usable clock choice
  always_comb begin
    case (pulse_cnt_ff)
      3'h0:             nxt_clk_src = msps_pkg::clk_crystal;
      `PULSES_EXTERNAL: nxt_clk_src = msps_pkg::clk_external;
      default:          nxt_clk_src = msps_pkg::clk_invalid;
    endcase
  end

  // Mode sequence
  always_comb begin
    case (state_ff)
      msps_pkg::st_strap:
        if (settle_ff == `STRAP_SETTLE_CYC) begin
          nxt_state = mode_sync.clean ? msps_pkg::st_pulse : msps_pkg::st_normal;
        end else begin
          nxt_state = msps_pkg::st_strap;
        end
      msps_pkg::st_normal:
        nxt_state = msps_pkg::st_normal;
      msps_pkg::st_pulse:
        nxt_state = rx_sync.fall ? msps_pkg::st_baud : msps_pkg::st_pulse;
      msps_pkg::st_baud:
        nxt_state = rx_sync.rise ? msps_pkg::st_link : msps_pkg::st_baud;
      msps_pkg::st_link:
        nxt_state = msps_pkg::st_link;
      default:
        nxt_state = msps_pkg::st_strap;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mcr_ff <= `MCR_RESET;
    end else if (mcr_write) begin
      mcr_ff <= pwdata[7:0] & `MCR_WMASK;
    end
  end

  // APB answer one cycle into the access phase
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h00000000;
    end else begin
      pready_ff  <= answer;
      pslverr_ff <= answer & ~mapped;
      prdata_ff  <= (answer & ~pwrite) ? read_word : 32'h00000000;
    end
  end

  // Settle counter lets the filter see the pin before the strap is taken
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      settle_ff <= 3'h0;
    end else if (state_ff == msps_pkg::st_strap) begin
      settle_ff <= settle_ff + 3'h1;
    end
  end

  // count mode pulses
  // Falling edges are counted; saturates so a stuck pin cannot wrap to a valid code
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pulse_cnt_ff <= 3'h0;
    end else if ((state_ff == msps_pkg::st_pulse) && mode_sync.fall &&
                 (pulse_cnt_ff != 3'h7)) begin
      pulse_cnt_ff <= pulse_cnt_ff + 3'h1;
    end
  end

  // clock source lock
  // Taken at the first receive edge, the start of the reset command
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      clk_src_ff <= msps_pkg::clk_none;
    end else if ((state_ff == msps_pkg::st_pulse) && rx_sync.fall) begin
      clk_src_ff <= nxt_clk_src;
    end
  end

  // measure start bit
  // Low time of the first start bit gives the receive bit period
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      period_cnt_ff <= 12'h000;
      bit_period_ff <= `NOMINAL_BIT_CYC;
      locked_ff     <= 1'b0;
    end else if (state_ff == msps_pkg::st_baud) begin
      if (rx_sync.rise) begin
        // Count starts one cycle after the fall, so the fall cycle is added back
        bit_period_ff <= period_cnt_ff + 12'h001;
        locked_ff     <= 1'b1;
      end else if (period_cnt_ff != 12'hffe) begin
        period_cnt_ff <= period_cnt_ff + 12'h001;
      end
    end
  end

  // Registered outputs
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_ff       <= msps_pkg::st_strap;
      ram_bytes_ff   <= 11'h000;
      rom_kb_ff      <= 6'h00;
    end else begin
      state_ff       <= nxt_state;
      ram_bytes_ff   <= nxt_ram_bytes;
      rom_kb_ff      <= nxt_rom_kb;
    end
  end

  // Mode dependent pin control
  logic prog_ff;
  logic hold_ff;
  logic xtal_ff;
  logic ext_ff;
  logic osc_en_ff;
  logic tx_ff;
  wire  in_prog = (nxt_state == msps_pkg::st_pulse) || (nxt_state == msps_pkg::st_baud) ||
                  (nxt_state == msps_pkg::st_link);
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      prog_ff   <= 1'b0;
      hold_ff   <= 1'b1;
      xtal_ff   <= 1'b0;
      ext_ff    <= 1'b0;
      osc_en_ff <= 1'b0;
      tx_ff     <= 1'b1;
    end else begin
      prog_ff   <= in_prog;
      hold_ff   <= in_prog || (nxt_state == msps_pkg::st_strap);
      xtal_ff   <= in_prog && (clk_src_ff == msps_pkg::clk_crystal);
      ext_ff    <= in_prog && (clk_src_ff == msps_pkg::clk_external);
      osc_en_ff <= (nxt_state == msps_pkg::st_normal);
      tx_ff     <= 1'b1;
    end
  end

  // transmit line idles high
  // Responses come from the serial engine elsewhere; this block only parks the line
  assign programming_transmit_line = tx_ff;
  assign prdata                = prdata_ff;
  assign pready                = pready_ff;
  assign pslverr               = pslverr_ff;
  assign prog_mode             = prog_ff;
  assign hold_pins_reset_state = hold_ff;
  assign alt_pair_disabled     = prog_ff;
  assign sel_crystal_clock     = xtal_ff;
  assign sel_external_clock    = ext_ff;
  assign internal_osc_enable   = osc_en_ff;
  assign baud_locked           = locked_ff;
  assign rx_bit_period         = bit_period_ff;
  assign hs_ram_bytes          = ram_bytes_ff;
  assign rom_kbytes            = rom_kb_ff;

  // Alternate receive input is deliberately unused
  wire unused_alt = alternate_receive_line;
endmodule
`default_nettype wire

// ### core/pin_filter.sv
// Purpose: Three-stage pin synchroniser with agreement filter and edge pulses
// Assumes: raw is asynchronous to ref_clk
// Notes:   Idle level is a parameter so reset does not fake an edge
`default_nettype none
module pin_filter #(
  parameter logic IDLE = 1'b0
) (
  input  wire logic  ref_clk,
  input  wire logic  rst,
  input  wire logic  raw,
  pin_sync_if.src    sync
);
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic clean_ff;
  logic rise_ff;
  logic fall_ff;
  wire  agree = (s2_ff == s3_ff);
  wire  nxt_clean = agree ? s3_ff : clean_ff;

  // First stage feeds only the second; level counts once stages two and three agree
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s1_ff    <= IDLE;
      s2_ff    <= IDLE;
      s3_ff    <= IDLE;
      clean_ff <= IDLE;
      rise_ff  <= 1'b0;
      fall_ff  <= 1'b0;
    end else begin
      s1_ff    <= raw;
      s2_ff    <= s1_ff;
      s3_ff    <= s2_ff;
      clean_ff <= nxt_clean;
      rise_ff  <= nxt_clean & ~clean_ff;
      fall_ff  <= ~nxt_clean & clean_ff;
    end
  end

  assign sync.clean = clean_ff;
  assign sync.rise  = rise_ff;
  assign sync.fall  = fall_ff;
endmodule
`default_nettype wire

// ### include/msps_consts.svh
// Purpose: Offsets, fields, reset values and timing counts for the memory size block
// Assumes: 100 MHz ref_clk, APB with 32-bit data
// Notes:   Function list below; tags appear in core/memory_size_and_program_mode.sv
`ifndef MSPS_CONSTS_SVH
`define MSPS_CONSTS_SVH

`define MCR_ADDR         16'hfff0
`define STATUS_ADDR      16'hfff4
`define MCR_RESET        8'hcf
`define MCR_WMASK        8'hef
`define RAM_FIELD_LSB    5
`define ROM_FIELD_MSB    3

`define RAM_SEL_768      3'h0
`define RAM_SEL_512      3'h2
`define RAM_SEL_1024     3'h6
`define ROM_SEL_8K       4'h2
`define ROM_SEL_16K      4'h4
`define ROM_SEL_24K      4'h6
`define ROM_SEL_32K      4'h8

`define ST_PROG_BIT      0
`define ST_CLK_LSB       1
`define ST_PULSE_LSB     3
`define ST_RAM_OK_BIT    6
`define ST_ROM_OK_BIT    7
`define ST_LOCK_BIT      8
`define ST_PERIOD_LSB    9

`define SYS_CLK_HZ       100000000
`define PROG_BAUD_BPS    115200
`define NOMINAL_BIT_CYC  12'((`SYS_CLK_HZ) / (`PROG_BAUD_BPS))
`define STRAP_SETTLE_CYC 3'h4
`define PULSES_EXTERNAL  3'h3

`endif

// ### include/msps_pkg.sv
// Purpose: Types shared by the memory size and programming mode block
// Assumes: Nothing
// Notes:   One-hot state codes written out
`default_nettype none
package msps_pkg;
  typedef enum logic [4:0] {
    st_strap  = 5'h01,
    st_normal = 5'h02,
    st_pulse  = 5'h04,
    st_baud   = 5'h08,
    st_link   = 5'h10
  } mode_state_type;

  typedef enum logic [1:0] {
    clk_none     = 2'h0,
    clk_crystal  = 2'h1,
    clk_external = 2'h2,
    clk_invalid  = 2'h3
  } clk_src_type;
endpackage
`default_nettype wire

// ### include/pin_sync_if.sv
// Purpose: Filtered pin level and its edges
// Assumes: Single ref_clk domain on the filtered side
// Notes:   Edges are one-cycle pulses
`default_nettype none
interface pin_sync_if;
  logic clean;
  logic rise;
  logic fall;
  modport src (output clean, output rise, output fall);
  modport dst (input clean, input rise, input fall);
endinterface
`default_nettype wire

// ### tb/flash_programmer_model.sv
// Purpose: Programmer stand-in driving the mode pin and serial receive line
// Assumes: One burst per go pulse from the bench
// Notes:   Sends the start bit only; data bits are not measured here
`default_nettype none
module flash_programmer_model (
  input  wire logic        ref_clk,
  input  wire logic        mode_req,
  input  wire logic        go,
  input  wire logic [2:0]  n_pulses,
  input  wire logic [11:0] low_cyc,
  output var  logic        flash_mode_pin,
  output var  logic        programming_receive_line
);
  timeunit 1ns;
  timeprecision 1ps;
  // Line idles high between frames
  initial begin
    flash_mode_pin = 1'b0;
    programming_receive_line = 1'b1;
  end
  // Mode level, then pulse burst and start bit
  always begin
    @(posedge ref_clk);
    if (go) begin
      repeat (n_pulses) begin
        flash_mode_pin <= 1'b0;
        repeat (4) @(posedge ref_clk);
        flash_mode_pin <= 1'b1;
        repeat (4) @(posedge ref_clk);
      end
      programming_receive_line <= 1'b0;
      repeat (low_cyc) @(posedge ref_clk);
      programming_receive_line <= 1'b1;
    end else begin
      flash_mode_pin <= mode_req;
    end
  end
endmodule
`default_nettype wire

// ### tb/memory_size_and_program_mode_monitor.sv
// Purpose: Concurrent checks on register bus and mode entry ports
// Assumes: Single ref_clk domain, rst asynchronous active high
// Notes:   Bound to the top module below
`include "msps_consts.svh"
`default_nettype none
module memory_size_and_program_mode_monitor (
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        flash_mode_pin,
  input wire logic        programming_transmit_line,
  input wire logic        prog_mode,
  input wire logic        hold_pins_reset_state,
  input wire logic        alt_pair_disabled,
  input wire logic        sel_crystal_clock,
  input wire logic        sel_external_clock,
  input wire logic        internal_osc_enable
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Bus answer and strap steps
  sequence s_ready_after_wait;
    !pready ##1 pready;
  endsequence
  sequence s_enter_prog;
    ##[1:10] prog_mode;
  endsequence
  // Register bus answer shape
  property p_wait_state; psel && !penable |=> s_ready_after_wait; endproperty
  property p_ready_pulse; pready |=> !pready; endproperty
  property p_unmapped;
    pready |-> pslverr == (paddr != `MCR_ADDR && paddr != `STATUS_ADDR);
  endproperty
  property p_err_zero; pready && pslverr |-> prdata == 32'h0; endproperty
  property p_bit4_zero;
    pready && !pwrite && paddr == `MCR_ADDR |-> prdata[31:8] == 24'h0 && !prdata[4];
  endproperty
  // Mode side of the block
  property p_tx_idle; programming_transmit_line; endproperty
  property p_prog_hold;
    prog_mode |-> hold_pins_reset_state && alt_pair_disabled && !internal_osc_enable;
  endproperty
  property p_clk_src;
    sel_crystal_clock || sel_external_clock |->
      prog_mode && !(sel_crystal_clock && sel_external_clock) && !internal_osc_enable;
  endproperty
  property p_strap_normal; $fell(rst) && !flash_mode_pin |-> !prog_mode [*8]; endproperty
  property p_strap_prog; $fell(rst) && flash_mode_pin |-> s_enter_prog; endproperty
  property p_prog_stays; prog_mode |=> prog_mode; endproperty
  a_wait_state: assert property (p_wait_state) else $error("no single wait state");
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready too long");
  a_unmapped: assert property (p_unmapped) else $error("bad error flag");
  a_err_zero: assert property (p_err_zero) else $error("error read not zero");
  a_bit4_zero: assert property (p_bit4_zero) else $error("reserved bits set");
  a_tx_idle: assert property (p_tx_idle) else $error("transmit not idle");
  a_prog_hold: assert property (p_prog_hold) else $error("pins not held");
  a_clk_src: assert property (p_clk_src) else $error("bad clock source");
  a_strap_normal: assert property (p_strap_normal) else $error("wrong mode entry");
  a_strap_prog: assert property (p_strap_prog) else $error("no mode entry");
  a_prog_stays: assert property (p_prog_stays) else $error("mode dropped");
endmodule
bind memory_size_and_program_mode memory_size_and_program_mode_monitor
  memory_size_and_program_mode_monitor_inst (.ref_clk, .rst, .psel, .penable, .pwrite,
  .paddr, .prdata, .pready, .pslverr, .flash_mode_pin, .programming_transmit_line,
  .prog_mode, .hold_pins_reset_state, .alt_pair_disabled, .sel_crystal_clock,
  .sel_external_clock, .internal_osc_enable);
`default_nettype wire

// ### tb/memory_size_and_program_mode_tb_top.sv
// Purpose: Self-checking bench for capacity register and programming entry
// Assumes: One wait state per bus access; model drives mode and receive pins
// Notes:   Bus results pass through a queue checked by a watcher process
`include "msps_consts.svh"
`default_nettype none
module memory_size_and_program_mode_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk, rst, psel, penable, pwrite, pready, pslverr, mode_req, go;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        flash_mode_pin, programming_receive_line, alternate_receive_line;
  logic        programming_transmit_line, prog_mode, hold_pins_reset_state;
  logic        alt_pair_disabled, sel_crystal_clock, sel_external_clock;
  logic        internal_osc_enable, baud_locked;
  logic [11:0] rx_bit_period;
  logic [10:0] hs_ram_bytes;
  logic [5:0]  rom_kbytes;
  logic [2:0]  n_pulses;
  logic [32:0] exp_q[$];
  logic [7:0]  legal[4] = '{8'h42, 8'h04, 8'hc6, 8'hc8};
  int          n_fail, check_count, cycles;

  memory_size_and_program_mode memory_size_and_program_mode_inst (
    .ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .flash_mode_pin, .programming_receive_line, .alternate_receive_line,
    .programming_transmit_line, .prog_mode, .hold_pins_reset_state, .alt_pair_disabled,
    .sel_crystal_clock, .sel_external_clock, .internal_osc_enable, .baud_locked,
    .rx_bit_period, .hs_ram_bytes, .rom_kbytes);
  flash_programmer_model flash_programmer_model_inst (
    .ref_clk, .mode_req, .go, .n_pulses, .low_cyc(12'h364), .flash_mode_pin,
    .programming_receive_line);

  function automatic logic [10:0] ram_of(input logic [2:0] c);
    return c == 3'h0 ? 11'h300 : c == 3'h2 ? 11'h200 : c == 3'h6 ? 11'h400 : 11'h0;
  endfunction
  function automatic logic [5:0] rom_of(input logic [3:0] c);
    return c == 4'h2 ? 6'h08 : c == 4'h4 ? 6'h10 : c == 4'h6 ? 6'h18 : c == 4'h8 ? 6'h20 : 6'h0;
  endfunction

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Setup, access, hold until ready; expected answer queued first
  task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d,
                     input logic [32:0] e);
    @(posedge ref_clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    exp_q.push_back(e);
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic reset(input logic m);
    mode_req <= m;
    rst      <= 1'b1;
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (12) @(posedge ref_clk);
  endtask

  // Random upper bits must be ignored by the register
  task automatic wr_mcr(input logic [7:0] v);
    apb(1'b1, `MCR_ADDR, ($urandom() & 32'hffffff00) | 32'(v), 33'h0);
    apb(1'b0, `MCR_ADDR, 32'h0, {25'h0, v & `MCR_WMASK});
    repeat (3) @(posedge ref_clk);
    check(64'(hs_ram_bytes), 64'(ram_of(v[7:5])));
    check(64'(rom_kbytes), 64'(rom_of(v[3:0])));
  endtask

  // Strap into programming, pulse n times, send start bit
  task automatic prog(input logic [2:0] n, input logic [1:0] c);
    n_pulses <= n;
    reset(1'b1);
    go <= 1'b1;
    @(posedge ref_clk);
    go <= 1'b0;
    for (int i = 0; i < 2000 && baud_locked !== 1'b1; i++) @(posedge ref_clk);
    @(posedge ref_clk);
    check(64'({prog_mode, hold_pins_reset_state, alt_pair_disabled, internal_osc_enable,
               sel_crystal_clock, sel_external_clock}),
          64'({4'he, c == 2'h1, c == 2'h2}));
    check(64'(rx_bit_period), 64'(12'h364));
    apb(1'b0, `STATUS_ADDR, 32'h0, {12'h0, 12'h364, 3'h5, n, c, 1'b1});
  endtask

  task end_of_test();
    if (n_fail == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Free-running 100 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // Oldest queued answer compared when ready shows
  always @(posedge ref_clk) begin
    if (pready === 1'b1) check(64'({pslverr, prdata}), 64'(exp_q.pop_front()));
  end

  always @(posedge ref_clk) alternate_receive_line <= 1'($urandom());

  // Hang guard, well above the planned run length
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      end_of_test();
    end
  end

  initial begin
    void'($urandom(32'he749));
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 16'h0;
    pwdata = 32'h0;
    mode_req = 1'b0;
    go = 1'b0;
    n_pulses = 3'h0;
    alternate_receive_line = 1'b1;
    reset(1'b0);
    check(64'({prog_mode, internal_osc_enable, hs_ram_bytes, rom_kbytes}),
          64'({2'h1, 11'h400, 6'h0}));
    apb(1'b0, `MCR_ADDR, 32'h0, {25'h0, `MCR_RESET});
    for (int i = 0; i < 4; i++) wr_mcr(legal[i]);
    repeat (4) wr_mcr(8'($urandom()));
    apb(1'b1, 16'hfff8, 32'h000000ff, {1'b1, 32'h0});
    apb(1'b0, 16'hfff8, 32'h0, {1'b1, 32'h0});
    wr_mcr(8'h42);
    prog(3'h0, 2'h1);
    prog(3'h3, 2'h2);
    prog(3'h5, 2'h3);
    end_of_test();
  end
endmodule
`default_nettype wire
